// [aid_detector.sv]
// Activity/inactivity detector top: registers, threshold compare,
// duration counting, rate override and the two interrupt pins.
// Assumes filtered samples arrive with a one-cycle sample tick.
//
// Behaviour
// - Inactivity overrides accel rate, register kept
// - Activity restores accel settings and gyro
// - Global enable plus mode; 00 is stationary
// - Modes 01/10/11: gyro unchanged/sleep/off
// - Filter select: 0 slope, 1 high-pass
// - Six-bit threshold, weight scales LSB
// - Compare magnitude of signed filtered data
// - Inactive duration in 512-tick steps, zero means 16
// - Change pulse one sample on inactivity
// - Activity duration in ticks, zero one sample
// - Change pulse one sample on activity
// - Change routable per pin, readable twice
// - Pulsed flag, latched with latch and route unless state-on-pin
// - Sleep state bit shows current state
// - State-on-pin puts level on pins
// - Stationary mode changes no power state
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`default_nettype none
module aid_detector
  import aid_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // Filtered sample inputs, signed 16-bit per axis
  input  wire logic        SAMPLE_TICK,
  input  wire logic [15:0] SLOPE_X,
  input  wire logic [15:0] SLOPE_Y,
  input  wire logic [15:0] SLOPE_Z,
  input  wire logic [15:0] HPF_X,
  input  wire logic [15:0] HPF_Y,
  input  wire logic [15:0] HPF_Z,
  // Power control outputs
  output logic [3:0]       ACCEL_RATE_EFF,
  output logic             ACCEL_LOW_POWER,
  output aid_pkg::aid_gyro_e GYRO_MODE,
  output logic             SLEEP_STATE,
  // Interrupt pins
  output logic             IRQ_PIN_A,
  output logic             IRQ_PIN_B,
  output logic             IRQ,
  // AXI4-Lite slave
  input  wire logic [7:0]  S_AWADDR,
  input  wire logic        S_AWVALID,
  output logic             S_AWREADY,
  input  wire logic [31:0] S_WDATA,
  input  wire logic [3:0]  S_WSTRB,
  input  wire logic        S_WVALID,
  output logic             S_WREADY,
  output logic [1:0]       S_BRESP,
  output logic             S_BVALID,
  input  wire logic        S_BREADY,
  input  wire logic [7:0]  S_ARADDR,
  input  wire logic        S_ARVALID,
  output logic             S_ARREADY,
  output logic [31:0]      S_RDATA,
  output logic [1:0]       S_RRESP,
  output logic             S_RVALID,
  input  wire logic        S_RREADY
);
  typedef struct packed {
    logic [7:0]  accel_control;
    logic [7:0]  cfg_zero;
    logic [7:0]  cfg_two;
    logic [7:0]  ths;
    logic [7:0]  dur;
    logic [7:0]  route_a;
    logic [7:0]  route_b;
    logic [1:0]  irq_sts;
    logic [1:0]  irq_msk;
    logic        inactive;
    logic [12:0] quiet_cnt;
    logic [1:0]  act_cnt;
    logic        change_pulse;
    logic        change_latch;
    logic        pin_a;
    logic        pin_b;
  } aid_state_s;
  aid_state_s reg_ff, nxt_reg;

  logic        wr_stb;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic        wr_ok;
  logic        rd_stb;
  logic [7:0]  rd_addr;
  logic [7:0]  rd_data;
  logic        rd_ok;

  aid_axil u_axil (
    .CLK       (CLK),
    .RST_N     (RST_N),
    .s_awaddr  (S_AWADDR),
    .s_awvalid (S_AWVALID),
    .s_awready (S_AWREADY),
    .s_wdata   (S_WDATA),
    .s_wstrb   (S_WSTRB),
    .s_wvalid  (S_WVALID),
    .s_wready  (S_WREADY),
    .s_bresp   (S_BRESP),
    .s_bvalid  (S_BVALID),
    .s_bready  (S_BREADY),
    .s_araddr  (S_ARADDR),
    .s_arvalid (S_ARVALID),
    .s_arready (S_ARREADY),
    .s_rdata   (S_RDATA),
    .s_rresp   (S_RRESP),
    .s_rvalid  (S_RVALID),
    .s_rready  (S_RREADY),
    .wr_stb    (wr_stb),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_ok     (wr_ok),
    .rd_stb    (rd_stb),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .rd_ok     (rd_ok)
  );

  // Configuration fields
  logic       global_irq_enable;
  logic [1:0] inactivity_mode;
  logic       filter_select;
  logic       latch_irq_enable;
  logic       state_on_pin;
  logic [5:0] motion_threshold;
  logic       threshold_weight;
  logic [3:0] inactive_duration;
  logic [1:0] active_duration;
  logic       route_change_pin_a;
  logic       route_change_pin_b;
  logic [3:0] accel_output_rate;
  logic       func_on;
  logic       latched_mode;

  assign global_irq_enable  = reg_ff.cfg_two[GLOBAL_IRQ_BIT];
  assign inactivity_mode    = reg_ff.cfg_two[INACT_MODE_LSB +: 2];
  assign filter_select      = reg_ff.cfg_zero[FILTER_SELECT_BIT];
  assign latch_irq_enable   = reg_ff.cfg_zero[LATCH_IRQ_BIT];
  assign state_on_pin       = reg_ff.cfg_zero[STATE_ON_PIN_BIT];
  assign motion_threshold   = reg_ff.ths[THRESHOLD_LSB +: 6];
  assign threshold_weight   = reg_ff.dur[WEIGHT_BIT];
  assign inactive_duration  = reg_ff.dur[INACT_DUR_LSB +: 4];
  assign active_duration    = reg_ff.dur[ACT_DUR_LSB +: 2];
  assign route_change_pin_a = reg_ff.route_a[ROUTE_CHANGE_BIT];
  assign route_change_pin_b = reg_ff.route_b[ROUTE_CHANGE_BIT];
  assign accel_output_rate  = reg_ff.accel_control[ACCEL_RATE_LSB +: 4];
  assign func_on = global_irq_enable;
  assign latched_mode = latch_irq_enable && !state_on_pin &&
                        (route_change_pin_a || route_change_pin_b);

  // Threshold compare on all three axes
  logic [15:0] ths_val;
  logic [2:0]  over;
  logic [15:0] axis_val [3];
  assign axis_val[0] = filter_select ? HPF_X : SLOPE_X;
  assign axis_val[1] = filter_select ? HPF_Y : SLOPE_Y;
  assign axis_val[2] = filter_select ? HPF_Z : SLOPE_Z;
  // threshold weight: full scale is 2^15, LSB is 2^9 or 2^7
  assign ths_val = threshold_weight ? {3'b000, motion_threshold, 7'h00}
                                    : {1'b0, motion_threshold, 9'h000};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_axis
      logic [15:0] mag;
      assign mag = axis_val[gi][15] ? 16'(-axis_val[gi]) : axis_val[gi];
      assign over[gi] = mag > ths_val;
    end
  endgenerate

  // Inactivity duration target in ticks
  logic [12:0] quiet_target;
  assign quiet_target = (inactive_duration == 4'h0) ?
                        13'(INACT_ZERO_TICKS) :
                        13'(INACT_UNIT * inactive_duration);

  // Register read decode
  always_comb begin
    rd_ok   = 1'b1;
    rd_data = 8'h00;
    case (rd_addr)
      ACCEL_CONTROL_OFS:   rd_data = reg_ff.accel_control;
      DETECT_CFG_ZERO_OFS: rd_data = reg_ff.cfg_zero;
      DETECT_CFG_TWO_OFS:  rd_data = reg_ff.cfg_two;
      MOTION_THS_OFS:      rd_data = reg_ff.ths;
      MOTION_DUR_OFS:      rd_data = reg_ff.dur;
      PIN_A_ROUTING_OFS:   rd_data = reg_ff.route_a;
      PIN_B_ROUTING_OFS:   rd_data = reg_ff.route_b;
      MOTION_SOURCE_OFS: begin
        rd_data[SRC_STATE_BIT]  = reg_ff.inactive;
        rd_data[SRC_CHANGE_BIT] = reg_ff.change_pulse || reg_ff.change_latch;
      end
      COMBINED_SOURCE_OFS: begin
        rd_data[SRC_CHANGE_BIT] = reg_ff.change_pulse || reg_ff.change_latch;
      end
      IRQ_STATUS_OFS:      rd_data = {6'h00, reg_ff.irq_sts};
      IRQ_MASK_OFS:        rd_data = {6'h00, reg_ff.irq_msk};
      default:             rd_ok = 1'b0;
    endcase
  end

  // Write address check
  always_comb begin
    case (wr_addr)
      ACCEL_CONTROL_OFS, DETECT_CFG_ZERO_OFS, DETECT_CFG_TWO_OFS,
      MOTION_THS_OFS, MOTION_DUR_OFS, PIN_A_ROUTING_OFS,
      PIN_B_ROUTING_OFS, IRQ_STATUS_OFS, IRQ_MASK_OFS: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Next-state logic
  logic go_inactive;
  logic go_active;
  logic src_read;
  always_comb begin
    nxt_reg     = reg_ff;
    go_inactive = 1'b0;
    go_active   = 1'b0;
    src_read    = rd_stb && (rd_addr == MOTION_SOURCE_OFS ||
                             rd_addr == COMBINED_SOURCE_OFS);
    // Register writes
    if (wr_stb) begin
      case (wr_addr)
        ACCEL_CONTROL_OFS:   nxt_reg.accel_control = wr_data;
        DETECT_CFG_ZERO_OFS: nxt_reg.cfg_zero = wr_data;
        DETECT_CFG_TWO_OFS:  nxt_reg.cfg_two  = wr_data;
        MOTION_THS_OFS:      nxt_reg.ths      = wr_data;
        MOTION_DUR_OFS:      nxt_reg.dur      = wr_data;
        PIN_A_ROUTING_OFS:   nxt_reg.route_a  = wr_data;
        PIN_B_ROUTING_OFS:   nxt_reg.route_b  = wr_data;
        IRQ_STATUS_OFS:      nxt_reg.irq_sts = reg_ff.irq_sts & ~wr_data[1:0];
        IRQ_MASK_OFS:        nxt_reg.irq_msk  = wr_data[1:0];
        default:             nxt_reg.irq_msk  = reg_ff.irq_msk;
      endcase
    end
    if (src_read) begin
      nxt_reg.change_latch = 1'b0;
    end
    if (!func_on) begin
      nxt_reg.inactive     = 1'b0;
      nxt_reg.quiet_cnt    = '0;
      nxt_reg.act_cnt      = '0;
      nxt_reg.change_pulse = 1'b0;
    end else if (SAMPLE_TICK) begin
      nxt_reg.change_pulse = 1'b0;
      if (!reg_ff.inactive) begin
        if (|over) begin
          nxt_reg.quiet_cnt = '0;
        end else if (reg_ff.quiet_cnt + 13'd1 >= quiet_target) begin
          go_inactive       = 1'b1;
          nxt_reg.quiet_cnt = '0;
        end else begin
          nxt_reg.quiet_cnt = reg_ff.quiet_cnt + 13'd1;
        end
      end else begin
        if (!(|over)) begin
          nxt_reg.act_cnt = '0;
        end else if (reg_ff.act_cnt >= active_duration) begin
          go_active       = 1'b1;
          nxt_reg.act_cnt = '0;
        end else begin
          nxt_reg.act_cnt = reg_ff.act_cnt + 2'd1;
        end
      end
    end
    if (go_inactive || go_active) begin
      nxt_reg.inactive     = go_inactive;
      nxt_reg.change_pulse = 1'b1;
      nxt_reg.irq_sts[0]   = nxt_reg.irq_sts[0] | go_inactive;
      nxt_reg.irq_sts[1]   = nxt_reg.irq_sts[1] | go_active;
      if (latched_mode) begin
        nxt_reg.change_latch = 1'b1;
      end
    end
    if (state_on_pin) begin
      nxt_reg.pin_a = route_change_pin_a && nxt_reg.inactive;
      nxt_reg.pin_b = route_change_pin_b && nxt_reg.inactive;
    end else begin
      nxt_reg.pin_a = route_change_pin_a &&
                      (nxt_reg.change_pulse || nxt_reg.change_latch);
      nxt_reg.pin_b = route_change_pin_b &&
                      (nxt_reg.change_pulse || nxt_reg.change_latch);
    end
  end

  // State register; configuration bytes start at their reset value
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      reg_ff               <= '0;
      reg_ff.accel_control <= CFG_RESET;
      reg_ff.cfg_zero      <= CFG_RESET;
      reg_ff.cfg_two       <= CFG_RESET;
      reg_ff.ths           <= CFG_RESET;
      reg_ff.dur           <= CFG_RESET;
      reg_ff.route_a       <= CFG_RESET;
      reg_ff.route_b       <= CFG_RESET;
    end else begin
      reg_ff <= nxt_reg;
    end
  end

  // Power control: override only with a rate mode
  logic power_save;
  assign power_save = reg_ff.inactive && (inactivity_mode != 2'b00);
  always_comb begin
    ACCEL_RATE_EFF  = power_save ? RATE_LOW_POWER : accel_output_rate;
    ACCEL_LOW_POWER = power_save;
    GYRO_MODE       = AID_GYRO_ON;
    if (power_save) begin
      case (inactivity_mode)
        2'b10:   GYRO_MODE = AID_GYRO_SLEEP;
        2'b11:   GYRO_MODE = AID_GYRO_OFF;
        default: GYRO_MODE = AID_GYRO_ON;
      endcase
    end
  end

  // Outputs
  assign SLEEP_STATE = reg_ff.inactive;
  assign IRQ_PIN_A   = reg_ff.pin_a;
  assign IRQ_PIN_B   = reg_ff.pin_b;
  assign IRQ         = |(reg_ff.irq_sts & reg_ff.irq_msk);
endmodule
`default_nettype wire

// [aid_pkg.sv]
// Package for the activity/inactivity detector: register map, fields,
// reset values and timing counts.
// Assumes a 250 MHz system clock and AXI4-Lite register access.
`default_nettype none
package aid_pkg;
  // Register byte offsets
  localparam logic [7:0] ACCEL_CONTROL_OFS   = 8'h00;
  localparam logic [7:0] DETECT_CFG_ZERO_OFS = 8'h04;
  localparam logic [7:0] DETECT_CFG_TWO_OFS  = 8'h08;
  localparam logic [7:0] MOTION_THS_OFS      = 8'h0C;
  localparam logic [7:0] MOTION_DUR_OFS      = 8'h10;
  localparam logic [7:0] PIN_A_ROUTING_OFS   = 8'h14;
  localparam logic [7:0] PIN_B_ROUTING_OFS   = 8'h18;
  localparam logic [7:0] MOTION_SOURCE_OFS   = 8'h1C;
  localparam logic [7:0] COMBINED_SOURCE_OFS = 8'h20;
  localparam logic [7:0] IRQ_STATUS_OFS      = 8'h24;
  localparam logic [7:0] IRQ_MASK_OFS        = 8'h28;
  // Field positions
  localparam int ACCEL_RATE_LSB     = 4;  // accel_output_rate [7:4]
  localparam int FILTER_SELECT_BIT  = 4;  // in detect_config_zero
  localparam int STATE_ON_PIN_BIT   = 5;  // in detect_config_zero
  localparam int LATCH_IRQ_BIT      = 0;  // in detect_config_zero
  localparam int GLOBAL_IRQ_BIT     = 7;  // in detect_config_two
  localparam int INACT_MODE_LSB     = 5;  // inactivity_mode [6:5]
  localparam int THRESHOLD_LSB      = 0;  // motion_threshold [5:0]
  localparam int WEIGHT_BIT         = 4;  // in motion_duration_reg
  localparam int INACT_DUR_LSB      = 0;  // inactive_duration [3:0]
  localparam int ACT_DUR_LSB        = 5;  // active_duration [6:5]
  localparam int ROUTE_CHANGE_BIT   = 7;  // in pin routing regs
  localparam int SRC_STATE_BIT      = 4;  // sleep state in source reg
  localparam int SRC_CHANGE_BIT     = 5;  // change flag in source reg
  // Reset values
  localparam logic [7:0] CFG_RESET  = 8'h00;
  // Rates and durations
  localparam logic [3:0] RATE_LOW_POWER = 4'h1;  // 12.5 Hz code
  localparam int INACT_UNIT        = 512;
  localparam int INACT_ZERO_TICKS  = 16;
  // Gyro power states
  typedef enum logic [1:0] {
    AID_GYRO_ON, AID_GYRO_SLEEP, AID_GYRO_OFF
  } aid_gyro_e;
endpackage
`default_nettype wire

// [aid_axil.sv]
// AXI4-Lite slave front end: turns bus transfers into one-cycle register
// write and read strobes.
// Assumes one clock, synchronous active-low reset, single outstanding ops.
`default_nettype none
module aid_axil (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // Register side
  output logic             wr_stb,
  output logic [7:0]       wr_addr,
  output logic [7:0]       wr_data,
  input  wire logic        wr_ok,
  output logic             rd_stb,
  output logic [7:0]       rd_addr,
  input  wire logic [7:0]  rd_data,
  input  wire logic        rd_ok
);
  typedef struct packed {
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [7:0]  wdata;
    logic        wlane;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } aid_axil_s;
  aid_axil_s reg_ff, nxt_reg;

  // Handshake readies and strobes
  assign s_awready = !reg_ff.aw_got && !reg_ff.bvalid;
  assign s_wready  = !reg_ff.w_got && !reg_ff.bvalid;
  assign s_arready = !reg_ff.rvalid;
  assign wr_stb  = reg_ff.aw_got && reg_ff.w_got && reg_ff.wlane;
  assign wr_addr = reg_ff.awaddr;
  assign wr_data = reg_ff.wdata;
  assign rd_stb  = s_arvalid && s_arready;
  assign rd_addr = s_araddr;
  assign s_bvalid = reg_ff.bvalid;
  assign s_bresp  = reg_ff.bresp;
  assign s_rvalid = reg_ff.rvalid;
  assign s_rresp  = reg_ff.rresp;
  assign s_rdata  = reg_ff.rdata;

  // Next-state logic
  always_comb begin
    nxt_reg = reg_ff;
    if (s_awvalid && s_awready) begin
      nxt_reg.aw_got = 1'b1;
      nxt_reg.awaddr = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      nxt_reg.w_got = 1'b1;
      nxt_reg.wdata = s_wdata[7:0];
      nxt_reg.wlane = s_wstrb[0];
    end
    if (reg_ff.aw_got && reg_ff.w_got) begin
      nxt_reg.aw_got = 1'b0;
      nxt_reg.w_got  = 1'b0;
      nxt_reg.bvalid = 1'b1;
      nxt_reg.bresp  = wr_ok ? 2'b00 : 2'b10;
    end
    if (reg_ff.bvalid && s_bready) begin
      nxt_reg.bvalid = 1'b0;
    end
    if (rd_stb) begin
      nxt_reg.rvalid = 1'b1;
      nxt_reg.rdata  = {24'h00_0000, rd_data};
      nxt_reg.rresp  = rd_ok ? 2'b00 : 2'b10;
    end else if (reg_ff.rvalid && s_rready) begin
      nxt_reg.rvalid = 1'b0;
    end
  end

  // State register
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      reg_ff <= '0;
    end else begin
      reg_ff <= nxt_reg;
    end
  end
endmodule
`default_nettype wire

// [aid_detector_sva.sv]
// Checker for the detector top: power override, state timing, bus timing.
// Assumes it is bound to aid_detector and sees only that module's ports.
`default_nettype none
module aid_detector_sva
  import aid_pkg::*;
(
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RST_N,
  // Detector side
  input  wire logic       SAMPLE_TICK,
  input  wire logic [3:0] ACCEL_RATE_EFF,
  input  wire logic       ACCEL_LOW_POWER,
  input  wire aid_pkg::aid_gyro_e GYRO_MODE,
  input  wire logic       SLEEP_STATE,
  input  wire logic       IRQ,
  // Bus handshakes
  input  wire logic       S_AWVALID,
  input  wire logic       S_AWREADY,
  input  wire logic       S_WVALID,
  input  wire logic       S_WREADY,
  input  wire logic       S_BVALID,
  input  wire logic       S_ARVALID,
  input  wire logic       S_ARREADY,
  input  wire logic       S_RVALID
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] awake_ff;
  logic [4:0] nxt_awake;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Ticks seen while awake, saturating; an upper bound on the quiet run
  always_comb begin
    nxt_awake = awake_ff;
    if (SLEEP_STATE) nxt_awake = 5'h00;
    else if (SAMPLE_TICK && awake_ff != 5'h1F) nxt_awake = awake_ff + 5'h01;
  end
  // Counter register
  always_ff @(posedge CLK) begin
    if (!RST_N) awake_ff <= 5'h00;
    else awake_ff <= nxt_awake;
  end
  lp_rate_a:
    assert property (ACCEL_LOW_POWER |-> ACCEL_RATE_EFF == RATE_LOW_POWER)
    else $error("Rate not forced low while overridden");
  lp_sleep_a:
    assert property (ACCEL_LOW_POWER |-> SLEEP_STATE)
    else $error("Low power while active");
  gyro_lp_a:
    assert property (GYRO_MODE != AID_GYRO_ON
      |-> ACCEL_LOW_POWER || $past(ACCEL_LOW_POWER))
    else $error("Gyro parked without override");
  gyro_wake_a:
    assert property ($fell(SLEEP_STATE)
      |-> ##[0:1] (GYRO_MODE == AID_GYRO_ON && !ACCEL_LOW_POWER))
    else $error("Settings not restored on wake");
  sleep_tick_a:
    assert property ($rose(SLEEP_STATE)
      |-> $past(SAMPLE_TICK) || $past(SAMPLE_TICK, 2))
    else $error("Sleep entered off a sample tick");
  inact_cnt_a:
    assert property ($rose(SLEEP_STATE) |-> awake_ff >= 5'h10)
    else $error("Sleep entered too early");
  rd_lat_a:
    assert property (S_ARVALID && S_ARREADY |=> S_RVALID)
    else $error("Read answer late");
  wr_lat_a:
    assert property (S_AWVALID && S_AWREADY && S_WVALID && S_WREADY
      |-> ##[1:3] S_BVALID)
    else $error("Write answer late");
  // Main scenarios reached
  cover property ($rose(SLEEP_STATE));
  cover property (GYRO_MODE == AID_GYRO_OFF);
  cover property ($rose(IRQ));
endmodule
bind aid_detector aid_detector_sva u_sva (
  .CLK(CLK), .RST_N(RST_N), .SAMPLE_TICK(SAMPLE_TICK),
  .ACCEL_RATE_EFF(ACCEL_RATE_EFF), .ACCEL_LOW_POWER(ACCEL_LOW_POWER),
  .GYRO_MODE(GYRO_MODE), .SLEEP_STATE(SLEEP_STATE), .IRQ(IRQ),
  .S_AWVALID(S_AWVALID), .S_AWREADY(S_AWREADY), .S_WVALID(S_WVALID),
  .S_WREADY(S_WREADY), .S_BVALID(S_BVALID), .S_ARVALID(S_ARVALID),
  .S_ARREADY(S_ARREADY), .S_RVALID(S_RVALID));
`default_nettype wire

// [aid_host.sv]
// Host model: AXI4-Lite master that software uses to reach the registers.
// Assumes one clock; its tasks wait without limit, the bench cuts hangs.
`default_nettype none
module aid_host (
  // Clock
  input  wire logic        CLK,
  // AXI4-Lite master
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // Write one byte; address and data offered together, each held to ready
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge CLK);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h00_0000, d};
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge CLK);
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge CLK);
    r = bresp;
    bready <= 1'b0;
  endtask
  // Read one word; ready held until the answer is sampled
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge CLK);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge CLK); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge CLK);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [aid_detector_tb.sv]
// Bench for the detector: feeds samples, programs registers, checks pins.
// Assumes aid_host as bus master and the bound checker beside uut.
`default_nettype none
module aid_detector_tb
  import aid_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        tick = 1'b0;
  logic [15:0] sl [3] = '{3{16'h0000}};
  logic [15:0] hp [3] = '{3{16'h0000}};
  logic [3:0]  rate;
  aid_gyro_e   gyro;
  logic        lp, sleep, pa, pb, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, dat;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          errors = 0;
  int          checked = 0;
  int          cycles = 0;
  // Design and host
  aid_detector uut (
    .CLK(clk), .RST_N(rst_n), .SAMPLE_TICK(tick),
    .SLOPE_X(sl[0]), .SLOPE_Y(sl[1]), .SLOPE_Z(sl[2]),
    .HPF_X(hp[0]), .HPF_Y(hp[1]), .HPF_Z(hp[2]),
    .ACCEL_RATE_EFF(rate), .ACCEL_LOW_POWER(lp), .GYRO_MODE(gyro),
    .SLEEP_STATE(sleep), .IRQ_PIN_A(pa), .IRQ_PIN_B(pb), .IRQ(irq),
    .S_AWADDR(awaddr), .S_AWVALID(awvalid), .S_AWREADY(awready),
    .S_WDATA(wdata), .S_WSTRB(wstrb), .S_WVALID(wvalid),
    .S_WREADY(wready), .S_BRESP(bresp), .S_BVALID(bvalid),
    .S_BREADY(bready), .S_ARADDR(araddr), .S_ARVALID(arvalid),
    .S_ARREADY(arready), .S_RDATA(rdata), .S_RRESP(rresp),
    .S_RVALID(rvalid), .S_RREADY(rready));
  aid_host host (
    .CLK(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  // 250 MHz clock
  always #2 clk = ~clk;
  // Cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      $display("[ERR] %0t run timed out", $time);
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d, rsp);
    chk(rsp, 2'b00);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  // One sample tick: s on slope, h on high-pass, both on axis ax
  task automatic smp(input logic [15:0] s, input logic [15:0] h,
                     input int ax);
    @(posedge clk);
    for (int i = 0; i < 3; i++) begin
      sl[i] <= (i == ax) ? s : 16'h0000;
      hp[i] <= (i == ax) ? h : 16'h0000;
    end
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    settle();
  endtask
  task automatic quiet(input int n);
    repeat (n) smp(16'h0000, 16'h0000, 0);
  endtask
  task automatic t_regs();
    host.rd(ACCEL_CONTROL_OFS, dat, rsp);
    chk(dat, 32'h0000_0000);
    w(ACCEL_CONTROL_OFS, 8'h50);
    host.rd(8'h30, dat, rsp);
    chk(rsp, 2'b10);
    chk(dat, 32'h0000_0000);
  endtask
  // Every mode; threshold edge, both weights, both sources, sign
  task automatic t_modes();
    logic [15:0] v;
    for (int m = 0; m < 4; m++) begin
      v = (m == 3) ? 16'h0100 : 16'h0400;
      w(DETECT_CFG_ZERO_OFS, (m == 2) ? 8'h10 : 8'h00);
      w(MOTION_DUR_OFS, (m == 3) ? 8'h10 : 8'h00);
      w(MOTION_THS_OFS, 8'h02);
      w(PIN_A_ROUTING_OFS, 8'h80);
      w(DETECT_CFG_TWO_OFS, 8'h80 | 8'(m << 5));
      quiet(15);
      chk(sleep, 1'b0);
      quiet(1);
      chk(sleep, 1'b1);
      chk(rate, (m == 0) ? 4'h5 : RATE_LOW_POWER);
      chk(lp, m != 0);
      chk(gyro, (m == 2) ? AID_GYRO_SLEEP
          : (m == 3) ? AID_GYRO_OFF : AID_GYRO_ON);
      chk(pa, 1'b1);
      chk(pb, 1'b0);
      host.rd(ACCEL_CONTROL_OFS, dat, rsp);
      chk(dat, 32'h0000_0050);
      if (m == 2) smp(16'h8001, -v, m % 3);
      else smp(-v, 16'h8001, m % 3);
      chk(sleep, 1'b1);
      chk(pa, 1'b0);
      if (m == 2) smp(16'h0000, -v - 16'h0001, m % 3);
      else smp(-v - 16'h0001, 16'h0000, m % 3);
      chk(sleep, 1'b0);
      chk(rate, 4'h5);
      chk(gyro, AID_GYRO_ON);
      chk(pa, 1'b1);
    end
    w(DETECT_CFG_TWO_OFS, 8'h20);
    quiet(16);
    chk(sleep, 1'b0);
  endtask
  // Latched flag, status, mask and clear
  task automatic t_latch();
    w(IRQ_STATUS_OFS, 8'h03);
    w(DETECT_CFG_ZERO_OFS, 8'h01);
    w(MOTION_DUR_OFS, 8'h00);
    w(DETECT_CFG_TWO_OFS, 8'hA0);
    quiet(18);
    chk(pa, 1'b1);
    chk(irq, 1'b0);
    w(IRQ_MASK_OFS, 8'h01);
    settle();
    chk(irq, 1'b1);
    host.rd(COMBINED_SOURCE_OFS, dat, rsp);
    chk(dat, 32'h0000_0020);
    host.rd(MOTION_SOURCE_OFS, dat, rsp);
    chk(dat, 32'h0000_0010);
    settle();
    chk(pa, 1'b0);
    w(IRQ_STATUS_OFS, 8'h01);
    settle();
    chk(irq, 1'b0);
    smp(16'h7FFF, 16'h0000, 0);
    chk(sleep, 1'b0);
    host.rd(IRQ_STATUS_OFS, dat, rsp);
    chk(dat, 32'h0000_0002);
  endtask
  // State level on pin b; broken runs restart both counts
  task automatic t_level();
    w(DETECT_CFG_ZERO_OFS, 8'h20);
    w(PIN_A_ROUTING_OFS, 8'h00);
    w(PIN_B_ROUTING_OFS, 8'h80);
    w(MOTION_DUR_OFS, 8'h60);
    quiet(15);
    smp(16'h7FFF, 16'h0000, 1);
    quiet(15);
    chk(sleep, 1'b0);
    quiet(4);
    chk(pb, 1'b1);
    repeat (3) smp(16'h7FFF, 16'h0000, 2);
    quiet(1);
    repeat (3) smp(16'h7FFF, 16'h0000, 2);
    chk(sleep, 1'b1);
    smp(16'h7FFF, 16'h0000, 2);
    chk(sleep, 1'b0);
    chk(pb, 1'b0);
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_modes();
    t_latch();
    t_level();
    give_verdict();
  end
endmodule
`default_nettype wire
